// ---- logic/wdog_defs.svh ----
// Offsets, field positions, reset values and timing counts of the watchdog interval timer
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH

// Register offsets (byte addresses)
`define WDOG_OFS_RELOAD_VALUE       8'h00
`define WDOG_OFS_CONTROL            8'h04
`define WDOG_OFS_RESTART_STROBE     8'h08
`define WDOG_OFS_CURRENT_COUNT      8'h0c
`define WDOG_OFS_EXPIRY_STATUS      8'h10
`define WDOG_OFS_EXPIRY_IRQ_ENABLE  8'h14

// Control field positions
`define WDOG_CTL_RUN_ENABLE         0
`define WDOG_CTL_TEST               1
`define WDOG_CTL_STALL_SLEEP        2
`define WDOG_CTL_STALL_WEEK         3
`define WDOG_CTL_STALL_DEBUG        4
`define WDOG_CTL_IRQ_SELECT         9

// Status and interrupt enable field positions
`define WDOG_STS_EXPIRY_FLAG        0
`define WDOG_IEN_EXPIRY_INT         0

// Reset values
`define WDOG_RST_RELOAD             16'hffff
`define WDOG_RST_COUNT              16'hffff

// Timing: core clock rate, slow counting clock rate, slow periods per count
`define WDOG_CORE_HZ                25000000
`define WDOG_SLOW_HZ                32768
`define WDOG_SLOW_PER_COUNT         33
`define WDOG_SLOW_DIV               (`WDOG_CORE_HZ / `WDOG_SLOW_HZ)

`endif

// ---- logic/wdog_interval_timer.sv ----
// Watchdog interval timer: registers, down-counter and expiry actions
//
// Operation
// R1: Enabled counter not reloaded in time underflows and produces an expiry event.
// R2: Firmware writes the load value first, then sets the enable bit.
// R3: Clearing enable stops counting and gates the counting logic.
// R4: Counter reloads on load write, restart strobe write, or expiry.
// R5: One count per 33 periods of the 32 kHz clock.
// R6: Interval is the countdown time from the load value to zero.
// R7: Enabled stall holds the count; counting resumes from the held value.
// R8: Register accesses run on the host clock and complete at once.
// R9: Functional counting logic is paced by the 32 kHz clock.
// R10: System reset returns every register and logic to default; status flag and interrupt enable are reset only by keep_resetn.
// R11: Bits on the keep-on-expiry reset survive an expiry event.
// R12: Expiry pulse raises interrupt if bit 9 set, else resets the controller.
// R13: Interrupt-mode expiry clears the select bit by hardware.
// R14: Load field is 16-bit read/write, default ffff, write reloads counter.
// R15: Bit 4 stalls the counter while a debug session is active.
// R16: Bit 3 stalls the counter while the week timer is active.
// R17: Bit 2 stalls the counter while either sleep timer is active.
// R18: Expiry sets the watchdog flag of the power-fail and reset status.
// R19: Expiry event output stays set until system reset.
// R20: Firmware reloads more often than the programmed interval.
// R21: Restart strobe reloads only while enabled; reads return zero.
// R22: Control bit 0 is the enable, default zero.
// R23: Count register is a read-only view of the counter, default ffff.
// R24: Status bit is write-one-clear and reset only by keep-on-expiry reset.
// R25: Stall is the OR of each source gated by its own enable.
// R26: Interrupt output is status bit AND interrupt enable bit.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"
module wdog_interval_timer #(
  parameter int SLOW_DIV       = `WDOG_SLOW_DIV,
  parameter int SLOW_PER_COUNT = `WDOG_SLOW_PER_COUNT
) (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     keep_resetn,
  input  wire wdog_pkg::wdog_host_req_t host_req,
  output logic                          host_ready,
  output logic [31:0]                   host_rdata,
  input  wire wdog_pkg::wdog_stall_src_t stall_src,
  output logic                          expiry_pulse,
  output logic                          expiry_event,
  output logic                          ec_subsys_reset,
  output logic                          pfr_wdog_set,
  output logic                          expiry_interrupt,
  output logic                          low_power
);
  import wdog_pkg::*;

  logic [15:0]  reload_q;
  logic [15:0]  count_q;
  wdog_ctrl_t   ctrl_q;
  logic         expiry_flag_q;
  logic         expiry_interrupt_en_q;
  logic         expiry_event_q;
  logic         expiry_pulse_q;
  logic         ec_reset_q;
  logic         pfr_set_q;
  logic [31:0]  rdata_q;
  wdog_state_t  state_q;
  wdog_state_t  state_d;

  logic         wr_hit;
  logic         rd_hit;
  logic         wr_reload;
  logic         wr_ctrl;
  logic         wr_strobe;
  logic         wr_status;
  logic         wr_ien;
  logic         kick;
  logic         stall;
  logic         run;
  logic         restart;
  logic         dec_tick;
  logic         expire;
  logic [2:0]   stall_active;
  logic [2:0]   stall_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Host access decode; every access is taken in the cycle it is offered
  assign host_ready = 1'b1; // R8
  assign wr_hit     = host_req.valid && host_req.write;
  assign rd_hit     = host_req.valid && !host_req.write;
  assign wr_reload  = wr_hit && (host_req.addr == `WDOG_OFS_RELOAD_VALUE);
  assign wr_ctrl    = wr_hit && (host_req.addr == `WDOG_OFS_CONTROL);
  assign wr_strobe  = wr_hit && (host_req.addr == `WDOG_OFS_RESTART_STROBE);
  assign wr_status  = wr_hit && (host_req.addr == `WDOG_OFS_EXPIRY_STATUS);
  assign wr_ien     = wr_hit && (host_req.addr == `WDOG_OFS_EXPIRY_IRQ_ENABLE);
  assign kick       = wr_strobe && ctrl_q.run_enable; // R21

  ////////////////////////////////////////////////////////////////////////////
  // Stall sources and counting pace
  assign stall_active = {stall_src.debug_active,
                         stall_src.week_timer_active,
                         |stall_src.sleep_timer_active}; // R17
  assign stall_enable = {ctrl_q.stall_debug_en, ctrl_q.stall_week_en, ctrl_q.stall_sleep_en}; // R15 R16 R17

  wdog_stall #(
    .NUM_SRC (3)
  ) u_stall (
    .src_active (stall_active),
    .src_enable (stall_enable),
    .stall      (stall)
  );

  assign run     = ctrl_q.run_enable && !stall; // R3 R7
  assign restart = wr_reload || kick;

  wdog_tick_div #(
    .SLOW_DIV       (SLOW_DIV),
    .SLOW_PER_COUNT (SLOW_PER_COUNT)
  ) u_tick (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .run       (run),
    .restart   (restart),
    .slow_tick (),
    .dec_tick  (dec_tick)
  );

  // Expiry on the count that would reach zero; a zero load expires on the next count
  // Count never steps down to zero while running: the expiry reload replaces the last step
  assign expire = dec_tick && (count_q <= 16'h0001); // R1 R6

  ////////////////////////////////////////////////////////////////////////////
  // Load register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reload_q <= `WDOG_RST_RELOAD; // R10 R14
    end else if (wr_reload) begin
      reload_q <= host_req.wdata[15:0]; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Down-counter; a load write takes priority over every other reload cause
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_q <= `WDOG_RST_COUNT; // R10 R23
    end else if (wr_reload) begin
      count_q <= host_req.wdata[15:0]; // R4 R14
    end else if (kick || expire) begin
      count_q <= reload_q; // R4 R21
    end else if (dec_tick) begin
      count_q <= count_q - 16'h0001; // R5 R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; a firmware write in the expiry cycle wins over the
  // hardware clear of the select bit, so the written value is never lost
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= '0; // R10 R22
    end else if (wr_ctrl) begin
      ctrl_q.run_enable        <= host_req.wdata[`WDOG_CTL_RUN_ENABLE]; // R2 R22
      ctrl_q.stall_sleep_en    <= host_req.wdata[`WDOG_CTL_STALL_SLEEP]; // R17
      ctrl_q.stall_week_en     <= host_req.wdata[`WDOG_CTL_STALL_WEEK]; // R16
      ctrl_q.stall_debug_en    <= host_req.wdata[`WDOG_CTL_STALL_DEBUG]; // R15
      ctrl_q.expiry_irq_select <= host_req.wdata[`WDOG_CTL_IRQ_SELECT];
    end else if (expire && ctrl_q.expiry_irq_select) begin
      ctrl_q.expiry_irq_select <= 1'b0; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt enable survive an expiry-driven system reset
  always_ff @(posedge core_clk) begin
    if (!keep_resetn) begin
      expiry_flag_q <= 1'b0; // R11 R24
    end else if (expire && ctrl_q.expiry_irq_select) begin
      expiry_flag_q <= 1'b1; // R12 R13
    end else if (wr_status && host_req.wdata[`WDOG_STS_EXPIRY_FLAG]) begin
      expiry_flag_q <= 1'b0; // R24
    end
  end

  always_ff @(posedge core_clk) begin
    if (!keep_resetn) begin
      expiry_interrupt_en_q <= 1'b0; // R11
    end else if (wr_ien) begin
      expiry_interrupt_en_q <= host_req.wdata[`WDOG_IEN_EXPIRY_INT];
    end
  end

  assign expiry_interrupt = expiry_flag_q && expiry_interrupt_en_q; // R26

  ////////////////////////////////////////////////////////////////////////////
  // Expiry actions, one register per output so each pulse stands one cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      expiry_pulse_q <= 1'b0;
    end else begin
      expiry_pulse_q <= expire; // R12
    end
  end

  // Mode comes from the select bit before the hardware clears it in that cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ec_reset_q <= 1'b0;
    end else begin
      ec_reset_q <= expire && !ctrl_q.expiry_irq_select; // R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pfr_set_q <= 1'b0;
    end else begin
      pfr_set_q <= expire; // R18
    end
  end

  // Sticky until system reset; only the reset clears it, so no clear race exists
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      expiry_event_q <= 1'b0; // R10 R19
    end else if (expire) begin
      expiry_event_q <= 1'b1; // R19
    end
  end

  assign expiry_pulse    = expiry_pulse_q;
  assign ec_subsys_reset = ec_reset_q;
  assign pfr_wdog_set    = pfr_set_q;
  assign expiry_event    = expiry_event_q;

  ////////////////////////////////////////////////////////////////////////////
  // Power state: off while disabled, stalled while an enabled source is active
  always_comb begin
    state_d = state_q;
    // Disable outranks a stall, so switching off a stalled watchdog lands in off
    case (state_q)
      WDOG_ST_OFF: begin
        if (ctrl_q.run_enable) begin
          state_d = stall ? WDOG_ST_STALL : WDOG_ST_RUN;
        end
      end
      WDOG_ST_RUN: begin
        if (!ctrl_q.run_enable) begin
          state_d = WDOG_ST_OFF;
        end else if (stall) begin
          state_d = WDOG_ST_STALL;
        end
      end
      WDOG_ST_STALL: begin
        if (!ctrl_q.run_enable) begin
          state_d = WDOG_ST_OFF;
        end else if (!stall) begin
          state_d = WDOG_ST_RUN;
        end
      end
      default: begin
        state_d = WDOG_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= WDOG_ST_OFF;
    end else begin
      state_q <= state_d; // R3 R7
    end
  end

  assign low_power = (state_q != WDOG_ST_RUN); // R3 R7

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (rd_hit) begin
      rdata_q <= '0;
      // Reserved and test bits read as zero
      case (host_req.addr)
        `WDOG_OFS_RELOAD_VALUE: rdata_q[15:0] <= reload_q;
        `WDOG_OFS_CONTROL: begin
          rdata_q[`WDOG_CTL_RUN_ENABLE]  <= ctrl_q.run_enable;
          rdata_q[`WDOG_CTL_STALL_SLEEP] <= ctrl_q.stall_sleep_en;
          rdata_q[`WDOG_CTL_STALL_WEEK]  <= ctrl_q.stall_week_en;
          rdata_q[`WDOG_CTL_STALL_DEBUG] <= ctrl_q.stall_debug_en;
          rdata_q[`WDOG_CTL_IRQ_SELECT]  <= ctrl_q.expiry_irq_select;
        end
        `WDOG_OFS_RESTART_STROBE: rdata_q <= '0; // R21
        `WDOG_OFS_CURRENT_COUNT: rdata_q[15:0] <= count_q; // R23
        `WDOG_OFS_EXPIRY_STATUS: rdata_q[`WDOG_STS_EXPIRY_FLAG] <= expiry_flag_q; // R24
        `WDOG_OFS_EXPIRY_IRQ_ENABLE: rdata_q[`WDOG_IEN_EXPIRY_INT] <= expiry_interrupt_en_q;
        default: rdata_q <= '0;
      endcase
    end
  end

  assign host_rdata = rdata_q;

endmodule : wdog_interval_timer
`default_nettype wire

// ---- logic/wdog_pkg.sv ----
// Types shared by the watchdog interval timer modules
`default_nettype none
package wdog_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wdog_host_req_t;

  typedef struct packed {
    logic       debug_active;
    logic       week_timer_active;
    logic [1:0] sleep_timer_active;
  } wdog_stall_src_t;

  typedef struct packed {
    logic expiry_irq_select;
    logic stall_debug_en;
    logic stall_week_en;
    logic stall_sleep_en;
    logic run_enable;
  } wdog_ctrl_t;

  typedef enum logic [2:0] {
    WDOG_ST_OFF   = 3'b001,
    WDOG_ST_RUN   = 3'b010,
    WDOG_ST_STALL = 3'b100
  } wdog_state_t;

endpackage : wdog_pkg
`default_nettype wire

// ---- logic/wdog_stall.sv ----
// Stall combiner: each stall source gated by its own enable bit
`timescale 1ns/1ps
`default_nettype none
module wdog_stall #(
  parameter int NUM_SRC = 3
) (
  input  wire logic [NUM_SRC-1:0] src_active,
  input  wire logic [NUM_SRC-1:0] src_enable,
  output logic                    stall
);
  import wdog_pkg::*;

  logic [NUM_SRC-1:0] gated;

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      assign gated[i] = src_active[i] & src_enable[i]; // R25
    end
  endgenerate

  assign stall = |gated; // R25

endmodule : wdog_stall
`default_nettype wire

// ---- logic/wdog_tick_div.sv ----
// Slow-clock enable divider and per-count prescaler of the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"
module wdog_tick_div #(
  parameter int SLOW_DIV       = `WDOG_SLOW_DIV,
  parameter int SLOW_PER_COUNT = `WDOG_SLOW_PER_COUNT
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic run,
  input  wire logic restart,
  output logic      slow_tick,
  output logic      dec_tick
);
  import wdog_pkg::*;

  localparam int DW = $clog2(SLOW_DIV);
  localparam int PW = $clog2(SLOW_PER_COUNT);
  localparam logic [DW-1:0] DIV_LAST = DW'(SLOW_DIV - 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(SLOW_PER_COUNT - 1);

  logic [DW-1:0] div_q;
  logic [PW-1:0] pre_q;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running slow clock enable, stands in for the 32 kHz clock
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (div_q == DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign slow_tick = (div_q == DIV_LAST); // R9

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler holds while not running, so a stall resumes mid-count
  always_ff @(posedge core_clk) begin
    if (!resetn || restart) begin
      pre_q <= '0;
    end else if (run && slow_tick) begin // R5 R7
      if (pre_q == PRE_LAST) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  assign dec_tick = run && slow_tick && (pre_q == PRE_LAST) && !restart; // R5

endmodule : wdog_tick_div
`default_nettype wire

// ---- testbench/wdog_checker.sv ----
// Concurrent checks on the watchdog interval timer ports
`timescale 1ns/1ps
`default_nettype none
module wdog_checker #(
  parameter int SLOW_DIV       = 4,
  parameter int SLOW_PER_COUNT = 3
) (
  input wire logic                      core_clk,
  input wire logic                      resetn,
  input wire logic                      keep_resetn,
  input wire wdog_pkg::wdog_host_req_t  host_req,
  input wire logic                      host_ready,
  input wire logic [31:0]               host_rdata,
  input wire wdog_pkg::wdog_stall_src_t stall_src,
  input wire logic                      expiry_pulse,
  input wire logic                      expiry_event,
  input wire logic                      ec_subsys_reset,
  input wire logic                      pfr_wdog_set,
  input wire logic                      expiry_interrupt,
  input wire logic                      low_power
);
  import wdog_pkg::*;
  logic       en_q;
  logic       sel_q;
  logic [2:0] sten_q;
  logic       stall_c;
  // Shadow of the control bits; the select bit copy drops one cycle late, which the mode check tolerates
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      en_q   <= 1'b0;
      sel_q  <= 1'b0;
      sten_q <= 3'h0;
    end else if (host_req.valid && host_req.write && host_req.addr == 8'h04) begin
      en_q   <= host_req.wdata[0];
      sel_q  <= host_req.wdata[9];
      sten_q <= host_req.wdata[4:2];
    end else if (expiry_pulse) begin
      sel_q <= 1'b0;
    end
  end
  assign stall_c = (sten_q[2] & stall_src.debug_active) | (sten_q[1] & stall_src.week_timer_active)
                 | (sten_q[0] & (|stall_src.sleep_timer_active));
  ////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_hold; resetn && !(host_req.valid && !host_req.write) |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_kick_rd; host_req.valid && !host_req.write && host_req.addr == 8'h08 |=> host_rdata == 32'h0; endproperty
  a_kick_rd: assert property (p_kick_rd) else $error("restart strobe read not zero");
  property p_pfr; pfr_wdog_set == expiry_pulse; endproperty
  a_pfr: assert property (p_pfr) else $error("status flag pulse differs from expiry");
  property p_mode; expiry_pulse |-> ec_subsys_reset == !sel_q; endproperty
  a_mode: assert property (p_mode) else $error("expiry action does not follow select bit");
  property p_one; expiry_pulse |=> !expiry_pulse; endproperty
  a_one: assert property (p_one) else $error("expiry pulse longer than one cycle");
  property p_sticky; resetn && expiry_event |=> expiry_event; endproperty
  a_sticky: assert property (p_sticky) else $error("expiry event dropped without reset");
  property p_need_en; expiry_pulse |-> $past(en_q); endproperty
  a_need_en: assert property (p_need_en) else $error("expiry while disabled");
  property p_off_low; !en_q [*3] |-> low_power; endproperty
  a_off_low: assert property (p_off_low) else $error("disabled but not in low power");
  property p_stall_low; (en_q && stall_c) [*3] |-> low_power; endproperty
  a_stall_low: assert property (p_stall_low) else $error("stalled but not in low power");
  c_sub: cover property (expiry_pulse && ec_subsys_reset);
  c_irq: cover property (expiry_pulse && !ec_subsys_reset);
  c_stall: cover property (en_q && stall_c);
endmodule : wdog_checker

bind wdog_interval_timer wdog_checker #(.SLOW_DIV(SLOW_DIV), .SLOW_PER_COUNT(SLOW_PER_COUNT)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .keep_resetn(keep_resetn), .host_req(host_req),
  .host_ready(host_ready), .host_rdata(host_rdata), .stall_src(stall_src), .expiry_pulse(expiry_pulse),
  .expiry_event(expiry_event), .ec_subsys_reset(ec_subsys_reset), .pfr_wdog_set(pfr_wdog_set),
  .expiry_interrupt(expiry_interrupt), .low_power(low_power));
`default_nettype wire

// ---- testbench/wdog_interval_timer_test.sv ----
// Self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
module wdog_interval_timer_test;
  import wdog_pkg::*;
  localparam int DIV  = 4;
  localparam int SPC  = 3;
  localparam int TDEC = DIV * SPC;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } wdog_row_t;
  localparam wdog_row_t ROWS [15] = '{
    '{1'b0, 8'h00, 32'h0, 32'hffff}, '{1'b0, 8'h04, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'hffff},
    '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'h1234abcd, 32'habcd}, '{1'b1, 8'h0c, 32'h5, 32'habcd},
    '{1'b1, 8'h08, 32'hff, 32'h0}, '{1'b1, 8'h04, 32'hfffffffe, 32'h21c},
    '{1'b1, 8'h04, 32'h0, 32'h0}, '{1'b1, 8'h14, 32'hffffffff, 32'h1},
    '{1'b1, 8'h14, 32'h0, 32'h0}, '{1'b1, 8'h10, 32'h1, 32'h0},
    '{1'b1, 8'h18, 32'hffffffff, 32'h0}
  };
  logic            core_clk;
  logic            resetn;
  logic            keep_resetn;
  wdog_host_req_t  host_req;
  wdog_stall_src_t stall_src;
  logic [31:0]     host_rdata;
  logic [31:0]     q;
  logic            host_ready, expiry_pulse, expiry_event, ec_subsys_reset;
  logic            pfr_wdog_set, expiry_interrupt, low_power, last_sub, last_pfr;
  int              bad_count, comparisons, pulse_cnt, n, cyc;

  wdog_interval_timer #(.SLOW_DIV(DIV), .SLOW_PER_COUNT(SPC)) dut (
    .core_clk(core_clk), .resetn(resetn), .keep_resetn(keep_resetn), .host_req(host_req),
    .host_ready(host_ready), .host_rdata(host_rdata), .stall_src(stall_src), .expiry_pulse(expiry_pulse),
    .expiry_event(expiry_event), .ec_subsys_reset(ec_subsys_reset), .pfr_wdog_set(pfr_wdog_set),
    .expiry_interrupt(expiry_interrupt), .low_power(low_power));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Pulses last one cycle, so latch what came with them
  always @(posedge core_clk) begin
    if (expiry_pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
      last_sub  <= ec_subsys_reset;
      last_pfr  <= pfr_wdog_set;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    host_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge core_clk);
    host_req.valid <= 1'b0;
    #1 q = host_rdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q, e);
  endtask : rdchk
  task automatic wait_pulse;
    cyc = 0;
    while (pulse_cnt == n && cyc < 400) begin
      @(posedge core_clk);
      #1 cyc++;
    end
  endtask : wait_pulse
  task automatic print_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    keep_resetn = 1'b0;
    host_req = '0;
    stall_src = '0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    keep_resetn <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        bus(1'b1, ROWS[i].addr, ROWS[i].wdata);
      end
      rdchk(ROWS[i].addr, ROWS[i].exp);
    end
    chk("ready", host_ready, 1'b1);
    // Expiry resetting the subsystem; first slow tick phase is free running, hence the window
    bus(1'b1, 8'h00, 32'h2);
    n = pulse_cnt;
    bus(1'b1, 8'h04, 32'h1);
    wait_pulse();
    chk("expiries", pulse_cnt, n + 1);
    chk("interval", 32'(cyc >= 2 * TDEC - DIV && cyc <= 2 * TDEC + 4), 32'h1);
    chk("subsys reset", last_sub, 1'b1);
    chk("pfr flag", last_pfr, 1'b1);
    chk("irq line", expiry_interrupt, 1'b0);
    rdchk(8'h0c, 32'h2);
    chk("event", expiry_event, 1'b1);
    chk("run power", low_power, 1'b0);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    repeat (3 * TDEC) @(posedge core_clk);
    rdchk(8'h0c, q);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h04, 32'h1);
    n = pulse_cnt;
    repeat (10) begin
      repeat (TDEC) @(posedge core_clk);
      bus(1'b1, 8'h08, 32'h0);
    end
    chk("kicked", pulse_cnt, n);
    wait_pulse();
    chk("unkicked", pulse_cnt, n + 1);
    bus(1'b1, 8'h04, 32'h0);
    for (int s = 0; s < 5; s++) begin
      @(posedge core_clk);
      stall_src <= (s < 4) ? wdog_stall_src_t'(4'b1000 >> s) : wdog_stall_src_t'(4'hf);
      bus(1'b1, 8'h00, 32'h40);
      bus(1'b1, 8'h04, (s < 4) ? (32'h1 | (32'h10 >> (s < 2 ? s : 2))) : 32'h1);
      repeat (3 * TDEC) @(posedge core_clk);
      if (s < 4) begin
        rdchk(8'h0c, 32'h40);
        chk("low power", low_power, 1'b1);
        @(posedge core_clk);
        stall_src <= '0;
        repeat (3 * TDEC) @(posedge core_clk);
      end
      bus(1'b0, 8'h0c, 32'h0);
      chk("resumed", 32'(q >= 32'h3c && q <= 32'h3e), 32'h1);
      bus(1'b1, 8'h04, 32'h0);
    end
    @(posedge core_clk);
    stall_src <= '0;
    // Interrupt mode: select bit self-clears and the status flag drives the line
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b1, 8'h00, 32'h2);
    n = pulse_cnt;
    bus(1'b1, 8'h04, 32'h201);
    wait_pulse();
    chk("subsys in irq mode", last_sub, 1'b0);
    chk("irq line", expiry_interrupt, 1'b1);
    rdchk(8'h04, 32'h1);
    rdchk(8'h10, 32'h1);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h14, 32'h0);
    chk("irq masked", expiry_interrupt, 1'b0);
    bus(1'b1, 8'h14, 32'h1);
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk("event after reset", expiry_event, 1'b0);
    chk("irq kept", expiry_interrupt, 1'b1);
    rdchk(8'h00, 32'hffff);
    rdchk(8'h0c, 32'hffff);
    rdchk(8'h10, 32'h1);
    bus(1'b1, 8'h10, 32'h1);
    rdchk(8'h10, 32'h0);
    @(posedge core_clk);
    keep_resetn <= 1'b0;
    @(posedge core_clk);
    keep_resetn <= 1'b1;
    rdchk(8'h14, 32'h0);
    print_verdict();
  end
endmodule : wdog_interval_timer_test
`default_nettype wire
